//--- logic/cell_monitor_pkg.sv
package cell_monitor_pkg;

  // ==========================================================================
  // clock and time base
  localparam int CLK_PERIOD_NS = 100;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_CNT_W = 18;
  localparam int DIV_W = 12;

  // ==========================================================================
  // register map, byte wide
  localparam logic [7:0] ADDR_SETUP_BASE = 8'h00;
  localparam int SETUP_BYTES = 6;
  localparam logic [7:0] ADDR_CELL_A_BASE = 8'h08;
  localparam int CELL_A_BYTES = 6;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [15:0] CELL_RESULT_RST = 16'h0000;

  // status register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_KIND_LSB = 1;
  localparam int ST_RATE_LSB = 4;
  localparam int ST_IGN_BIT = 7;

  // setup byte fields
  localparam int ALT_RATE_BIT = 0;
  localparam int UV_HI_LSB = 0;
  localparam int OV_LO_LSB = 4;
  localparam int DISCHARGE_TIMEOUT_LSB = 4;
  localparam int CONTINUOUS_DISCHARGE_BIT = 3;
  localparam int FORCE_REDUNDANCY_FAIL_BIT = 2;
  localparam int REDUNDANCY_DISABLE_BIT = 1;
  localparam int DISCHARGE_TIMER_MONITOR_EN_BIT = 0;

  // command word fields
  localparam int CMD_W = 11;
  localparam int MD_LSB = 7;
  localparam int PUP_BIT = 6;
  localparam int DCP_BIT = 4;
  localparam logic [2:0] SEL_ALL = 3'h0;
  localparam logic [2:0] SEL_MAX_CELL = 3'h6;
  localparam logic [2:0] SEL_MAX_STAT = 3'h4;

  typedef enum logic [2:0] {
    RATE_27K = 3'h0, RATE_14K = 3'h1, RATE_7K = 3'h2, RATE_3K = 3'h3,
    RATE_2K = 3'h4, RATE_1K = 3'h5, RATE_422 = 3'h6, RATE_26 = 3'h7
  } rate_t;

  typedef enum logic [1:0] {
    KIND_CELL = 2'h0, KIND_OPEN_WIRE = 2'h1, KIND_AUX = 2'h2, KIND_STATUS = 2'h3
  } conv_kind_t;

  // conversion times in microseconds, indexed by rate_t
  localparam int CELL_ALL_US [8] = '{524, 699, 1200, 1900, 3300, 6100, 12000, 201000};
  localparam int CELL_ONE_US [8] = '{200, 229, 404, 520, 753, 1200, 2100, 34000};
  localparam int AUX_ALL_US [8] = '{521, 695, 1200, 1900, 3300, 6000, 12000, 183000};
  localparam int AUX_ONE_US [8] = '{200, 229, 403, 520, 752, 1200, 2100, 34000};
  localparam int STAT_ALL_US [8] = '{741, 858, 1600, 2000, 3000, 4800, 8500, 134000};
  localparam int STAT_ONE_US [8] = '{200, 229, 403, 520, 752, 1200, 2100, 34000};

  function automatic rate_t rate_decode(input logic [1:0] md, input logic alt);
    rate_t r;
    r = RATE_422;
    case ({alt, md})
      3'h0: r = RATE_422;
      3'h1: r = RATE_27K;
      3'h2: r = RATE_7K;
      3'h3: r = RATE_26;
      3'h4: r = RATE_1K;
      3'h5: r = RATE_14K;
      3'h6: r = RATE_3K;
      default: r = RATE_2K;
    endcase
    return r;
  endfunction

  function automatic logic [US_CNT_W-1:0] conv_time_us(input conv_kind_t k, input rate_t r,
                                                      input logic all);
    int t;
    case (k)
      KIND_AUX: t = all ? AUX_ALL_US[r] : AUX_ONE_US[r];
      KIND_STATUS: t = all ? STAT_ALL_US[r] : STAT_ONE_US[r];
      default: t = all ? CELL_ALL_US[r] : CELL_ONE_US[r];
    endcase
    return t[US_CNT_W-1:0];
  endfunction

endpackage

//--- logic/cmd_dec_if.sv
`timescale 1ns/100ps
interface cmd_dec_if;
  import cell_monitor_pkg::*;
  logic [CMD_W-1:0] cmd;
  logic alt_rate_option;
  logic valid;
  conv_kind_t kind;
  logic [2:0] chan;
  rate_t rate;
  logic discharge_allowed;
  logic open_wire_current_dir;
  modport decoder (input cmd, input alt_rate_option, output valid, output kind, output chan,
                   output rate, output discharge_allowed, output open_wire_current_dir);
  modport core (output cmd, output alt_rate_option, input valid, input kind, input chan,
                input rate, input discharge_allowed, input open_wire_current_dir);
endinterface

//--- logic/cell_cmd_decoder.sv
`timescale 1ns/100ps
module cell_cmd_decoder
  import cell_monitor_pkg::*;
(
  cmd_dec_if.decoder dec
);

  logic [2:0] sel;
  logic [3:0] mid;

  assign sel = dec.cmd[2:0];
  assign mid = dec.cmd[6:3];

  // ==========================================================================
  // opcode match and field extraction
  always_comb begin
    dec.valid = 1'b0;
    dec.kind = KIND_CELL;
    dec.chan = sel;
    dec.rate = rate_decode(dec.cmd[MD_LSB+1:MD_LSB], dec.alt_rate_option);
    dec.discharge_allowed = dec.cmd[DCP_BIT];
    dec.open_wire_current_dir = dec.cmd[PUP_BIT];
    case (dec.cmd[10:9])
      2'h1: begin
        if (dec.cmd[5] && !dec.cmd[3] && dec.cmd[6]) begin
          dec.kind = KIND_CELL;
          dec.valid = (sel <= SEL_MAX_CELL);
        end else if (dec.cmd[5] && dec.cmd[3]) begin
          dec.kind = KIND_OPEN_WIRE;
          dec.valid = (sel <= SEL_MAX_CELL);
        end
      end
      2'h2: begin
        if (mid == 4'hC) begin
          dec.kind = KIND_AUX;
          dec.valid = (sel <= SEL_MAX_CELL);
        end else if (mid == 4'hD) begin
          if (sel <= SEL_MAX_STAT) begin
            dec.kind = KIND_STATUS;
            dec.valid = 1'b1;
          end else if (sel <= SEL_MAX_CELL) begin
            dec.kind = KIND_AUX;
            dec.valid = 1'b1;
          end
        end
      end
      default: dec.valid = 1'b0;
    endcase
  end

endmodule // cell_cmd_decoder

//--- logic/cell_monitor_cmd_fields.sv
// Overview of operation
// - option set: speed 00/01/10/11 select 1kHz, 14kHz, 3kHz, 2kHz.
// - cell select 000 sweeps all six, 001-110 one cell; sweep 524us to 201ms.
// - aux select 000 sweeps all, 001 S0, 010-101 GPIO, 110 reference.
// - status select 0-4 only: 000 sweeps all, 001-100 single items.
// - status command with select 5 or 6 runs the matching aux conversion.
// - undervoltage threshold: low byte in setup 1, top nibble setup 2 low.
// - overvoltage threshold: low nibble setup 2 high, upper byte setup 3.
// - setup 5 holds timeout, continuous, force fail, redundancy off, monitor.
// - result A read only, cells 1-3, low byte then high byte.
`timescale 1ns/100ps
module cell_monitor_cmd_fields
  import cell_monitor_pkg::*;
#(
  parameter int unsigned CYC_PER_US_P = CYC_PER_US
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  input wire logic i_cmd_valid,
  input wire logic [CMD_W-1:0] i_cmd,
  output logic o_cmd_accepted,
  output logic o_cmd_ignored,
  input wire logic i_meas_wr,
  input wire logic [2:0] i_meas_cell,
  input wire logic [15:0] i_meas_data,
  output logic o_conv_start,
  output logic [1:0] o_conv_kind,
  output logic [2:0] o_conv_chan,
  output logic [2:0] o_adc_rate,
  output logic o_busy,
  output logic o_conv_done,
  output logic o_discharge_suspend,
  output logic o_pull_up_en,
  output logic o_pull_down_en,
  output logic [11:0] o_undervolt_threshold,
  output logic [11:0] o_overvolt_threshold,
  output logic [3:0] o_discharge_timeout,
  output logic o_continuous_discharge,
  output logic o_force_redundancy_fail,
  output logic o_redundancy_disable,
  output logic o_discharge_timer_monitor_en
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } conv_state_t;

  cmd_dec_if dec_bus ();

  // ==========================================================================
  // register file state
  logic [7:0] setup_r [SETUP_BYTES];
  logic [7:0] setup_nxt [SETUP_BYTES];
  logic [7:0] cell_res_r [CELL_A_BYTES];
  logic [7:0] cell_res_nxt [CELL_A_BYTES];
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic ign_flag_r;
  logic ign_flag_nxt;

  // ==========================================================================
  // conversion state
  conv_state_t state_r;
  conv_state_t state_nxt;
  conv_kind_t kind_r;
  conv_kind_t kind_nxt;
  logic [2:0] chan_r;
  logic [2:0] chan_nxt;
  rate_t rate_r;
  rate_t rate_nxt;
  logic [US_CNT_W-1:0] us_left_r;
  logic [US_CNT_W-1:0] us_left_nxt;
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic start_r;
  logic start_nxt;
  logic done_r;
  logic done_nxt;
  logic acc_r;
  logic acc_nxt;
  logic ign_r;
  logic ign_nxt;
  logic susp_r;
  logic susp_nxt;
  logic pup_r;
  logic pup_nxt;
  logic pdn_r;
  logic pdn_nxt;
  logic us_tick;
  logic take_cmd;

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] base, input int n);
    return (a >= base) && (a < base + 8'(n));
  endfunction

  function automatic logic [7:0] status_word(input logic busy, input conv_kind_t k,
                                              input rate_t r, input logic ign);
    logic [7:0] w;
    w = 8'h00;
    w[ST_BUSY_BIT] = busy;
    w[ST_KIND_LSB +: 2] = k;
    w[ST_RATE_LSB +: 3] = r;
    w[ST_IGN_BIT] = ign;
    return w;
  endfunction

  // ==========================================================================
  // command decoder
  assign dec_bus.cmd = i_cmd;
  assign dec_bus.alt_rate_option = setup_r[0][ALT_RATE_BIT];

  cell_cmd_decoder u_dec (
    .dec (dec_bus)
  );

  // ==========================================================================
  // register access
  always_comb begin
    logic [7:0] ofs;
    logic [2:0] slot;
    ofs = 8'h00;
    slot = 3'h0;
    setup_nxt = setup_r;
    cell_res_nxt = cell_res_r;
    if (i_wr_en && in_range(i_addr, ADDR_SETUP_BASE, SETUP_BYTES)) begin
      ofs = i_addr - ADDR_SETUP_BASE;
      setup_nxt[ofs[2:0]] = i_wr_data;
    end
    // result A is loaded only by the measurement side
    if (i_meas_wr && (i_meas_cell >= 3'h1) && (i_meas_cell <= 3'h3)) begin
      slot = 3'((i_meas_cell - 3'h1) << 1);
      cell_res_nxt[slot] = i_meas_data[7:0];
      cell_res_nxt[slot + 3'h1] = i_meas_data[15:8];
    end
  end

  // ==========================================================================
  // sticky refused-command flag
  always_comb begin
    ign_flag_nxt = ign_flag_r;
    if (i_wr_en && (i_addr == ADDR_STATUS) && i_wr_data[ST_IGN_BIT]) begin
      ign_flag_nxt = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (ign_r) begin
      ign_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ign_flag_r <= 1'b0;
    end else begin
      ign_flag_r <= ign_flag_nxt;
    end
  end

  // ==========================================================================
  // read port, data stands for one cycle only
  always_comb begin
    logic [7:0] ofs;
    ofs = 8'h00;
    rd_data_nxt = 8'h00;
    if (i_rd_en) begin
      if (in_range(i_addr, ADDR_SETUP_BASE, SETUP_BYTES)) begin
        ofs = i_addr - ADDR_SETUP_BASE;
        rd_data_nxt = setup_r[ofs[2:0]];
      end else if (in_range(i_addr, ADDR_CELL_A_BASE, CELL_A_BYTES)) begin
        ofs = i_addr - ADDR_CELL_A_BASE;
        rd_data_nxt = cell_res_r[ofs[2:0]];
      end else if (i_addr == ADDR_STATUS) begin
        rd_data_nxt = status_word(state_r == ST_CONV, kind_r, rate_r, ign_flag_r);
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < SETUP_BYTES; i++) begin
        setup_r[i] <= SETUP_RST;
      end
      for (int i = 0; i < CELL_A_BYTES; i++) begin
        cell_res_r[i] <= CELL_RESULT_RST[7:0];
      end
    end else begin
      setup_r <= setup_nxt;
      cell_res_r <= cell_res_nxt;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // ==========================================================================
  // conversion sequencer
  assign us_tick = (div_r == DIV_W'(CYC_PER_US_P - 1));
  assign take_cmd = i_cmd_valid && (state_r == ST_IDLE) && dec_bus.valid;

  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    chan_nxt = chan_r;
    rate_nxt = rate_r;
    us_left_nxt = us_left_r;
    start_nxt = 1'b0;
    done_nxt = 1'b0;
    acc_nxt = 1'b0;
    ign_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (take_cmd) begin
          state_nxt = ST_CONV;
          kind_nxt = dec_bus.kind;
          chan_nxt = dec_bus.chan;
          rate_nxt = dec_bus.rate;
          us_left_nxt = conv_time_us(dec_bus.kind, dec_bus.rate,
                                     dec_bus.chan == SEL_ALL);
          start_nxt = 1'b1;
          acc_nxt = 1'b1;
        end else if (i_cmd_valid) begin
          ign_nxt = 1'b1;
        end
      end
      ST_CONV: begin
        if (i_cmd_valid) begin
          ign_nxt = 1'b1;
        end
        if (us_tick) begin
          if (us_left_r <= US_CNT_W'(1)) begin
            us_left_nxt = '0;
            state_nxt = ST_IDLE;
            done_nxt = 1'b1;
          end else begin
            us_left_nxt = us_left_r - US_CNT_W'(1);
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
      kind_r <= KIND_CELL;
      chan_r <= 3'h0;
      rate_r <= RATE_422;
      us_left_r <= '0;
      start_r <= 1'b0;
      done_r <= 1'b0;
      acc_r <= 1'b0;
      ign_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      chan_r <= chan_nxt;
      rate_r <= rate_nxt;
      us_left_r <= us_left_nxt;
      start_r <= start_nxt;
      done_r <= done_nxt;
      acc_r <= acc_nxt;
      ign_r <= ign_nxt;
    end
  end

  // ==========================================================================
  // microsecond time base, runs only while converting
  always_comb begin
    div_nxt = '0;
    if (state_r == ST_CONV) begin
      div_nxt = us_tick ? '0 : div_r + DIV_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // ==========================================================================
  // front-end controls, held for the whole conversion
  always_comb begin
    susp_nxt = susp_r;
    pup_nxt = pup_r;
    pdn_nxt = pdn_r;
    if (take_cmd) begin
      // discharge only matters for cell measurements
      susp_nxt = (dec_bus.kind == KIND_CELL || dec_bus.kind == KIND_OPEN_WIRE)
                 && !dec_bus.discharge_allowed;
      pup_nxt = (dec_bus.kind == KIND_OPEN_WIRE) && dec_bus.open_wire_current_dir;
      pdn_nxt = (dec_bus.kind == KIND_OPEN_WIRE) && !dec_bus.open_wire_current_dir;
    end else if (state_nxt != ST_CONV) begin
      susp_nxt = 1'b0;
      pup_nxt = 1'b0;
      pdn_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      susp_r <= 1'b0;
      pup_r <= 1'b0;
      pdn_r <= 1'b0;
    end else begin
      susp_r <= susp_nxt;
      pup_r <= pup_nxt;
      pdn_r <= pdn_nxt;
    end
  end

  // ==========================================================================
  // outputs
  assign o_rd_data = rd_data_r;
  assign o_cmd_accepted = acc_r;
  assign o_cmd_ignored = ign_r;
  assign o_conv_start = start_r;
  assign o_conv_kind = kind_r;
  assign o_conv_chan = chan_r;
  assign o_adc_rate = rate_r;
  assign o_busy = (state_r == ST_CONV);
  assign o_conv_done = done_r;
  assign o_discharge_suspend = susp_r;
  assign o_pull_up_en = pup_r;
  assign o_pull_down_en = pdn_r;
  assign o_undervolt_threshold = {setup_r[2][UV_HI_LSB +: 4], setup_r[1]};
  assign o_overvolt_threshold = {setup_r[3], setup_r[2][OV_LO_LSB +: 4]};
  assign o_discharge_timeout = setup_r[5][DISCHARGE_TIMEOUT_LSB +: 4];
  assign o_continuous_discharge = setup_r[5][CONTINUOUS_DISCHARGE_BIT];
  assign o_force_redundancy_fail = setup_r[5][FORCE_REDUNDANCY_FAIL_BIT];
  assign o_redundancy_disable = setup_r[5][REDUNDANCY_DISABLE_BIT];
  assign o_discharge_timer_monitor_en = setup_r[5][DISCHARGE_TIMER_MONITOR_EN_BIT];

endmodule // cell_monitor_cmd_fields

//--- tb/cell_monitor_checker_assertions.sv
`timescale 1ns/100ps
module cell_monitor_checker
  import cell_monitor_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_cmd_valid,
  input wire logic [CMD_W-1:0] i_cmd,
  input wire logic o_cmd_ignored,
  input wire logic o_conv_start,
  input wire logic [1:0] o_conv_kind,
  input wire logic [2:0] o_conv_chan,
  input wire logic o_busy,
  input wire logic o_conv_done,
  input wire logic o_discharge_suspend,
  input wire logic o_pull_up_en,
  input wire logic o_pull_down_en,
  input wire logic [11:0] o_undervolt_threshold,
  input wire logic [11:0] o_overvolt_threshold,
  input wire logic [3:0] o_discharge_timeout,
  input wire logic o_continuous_discharge,
  input wire logic o_force_redundancy_fail,
  input wire logic o_redundancy_disable,
  input wire logic o_discharge_timer_monitor_en
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================================
  // command word seen at the accepting edge
  logic [CMD_W-1:0] cmd_q_r;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) cmd_q_r <= '0;
    else cmd_q_r <= i_cmd;
  end
  wire cell_fam = cmd_q_r[10:9] == 2'b01;
  property p_busy_run; o_conv_start |-> o_busy [*8]; endproperty
  a_busy_run: assert property (p_busy_run) else $error("busy dropped early");
  property p_done_fall; o_conv_done |-> !o_busy && $past(o_busy); endproperty
  a_done_fall: assert property (p_done_fall) else $error("done without busy");
  property p_ign_busy; o_busy && i_cmd_valid |=> o_cmd_ignored && !o_conv_start; endproperty
  a_ign_busy: assert property (p_ign_busy) else $error("busy command taken");
  property p_uv; i_wr_en && i_addr == 8'h01 |=> o_undervolt_threshold[7:0] == $past(i_wr_data);
  endproperty
  a_uv: assert property (p_uv) else $error("undervolt low byte");
  property p_ov; i_wr_en && i_addr == 8'h03 |=> o_overvolt_threshold[11:4] == $past(i_wr_data);
  endproperty
  a_ov: assert property (p_ov) else $error("overvolt high byte");
  property p_cfg5;
    i_wr_en && i_addr == 8'h05 |=> {o_discharge_timeout, o_continuous_discharge,
      o_force_redundancy_fail, o_redundancy_disable, o_discharge_timer_monitor_en}
      == $past(i_wr_data);
  endproperty
  a_cfg5: assert property (p_cfg5) else $error("setup byte 5 fields");
  property p_chan; o_conv_start && cell_fam |-> o_conv_chan == cmd_q_r[2:0]; endproperty
  a_chan: assert property (p_chan) else $error("cell select lost");
  property p_susp; o_conv_start && cell_fam |-> o_discharge_suspend == !cmd_q_r[DCP_BIT];
  endproperty
  a_susp: assert property (p_susp) else $error("discharge suspend wrong");
  property p_pull;
    o_conv_start && cell_fam && cmd_q_r[3] |->
      o_pull_up_en == cmd_q_r[PUP_BIT] && o_pull_down_en == !cmd_q_r[PUP_BIT];
  endproperty
  a_pull: assert property (p_pull) else $error("open wire current wrong");
  property p_stat56;
    o_conv_start && cmd_q_r[10:9] == 2'b10 && cmd_q_r[6:3] == 4'hd
      && cmd_q_r[2:0] inside {3'h5, 3'h6}
      |-> o_conv_kind == KIND_AUX;
  endproperty
  a_stat56: assert property (p_stat56) else $error("status 5/6 not aux");
  c_start: cover property (o_conv_start);
  c_ign: cover property (o_cmd_ignored);
  c_done: cover property (o_conv_done);
endmodule // cell_monitor_checker

//--- tb/host_cmd_model.sv
`timescale 1ns/100ps
module host_cmd_model
  import cell_monitor_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_send,
  input wire logic [CMD_W-1:0] i_word,
  output logic o_cmd_valid,
  output logic [CMD_W-1:0] o_cmd
);
  // one-cycle strobe; word toggles when not qualified
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmd_valid <= 1'b0;
      o_cmd <= '0;
    end else begin
      o_cmd_valid <= i_send;
      o_cmd <= i_send ? i_word : ~o_cmd;
    end
  end
endmodule // host_cmd_model

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import cell_monitor_pkg::*;
  logic i_clk_sys, i_rst_n, i_wr_en, i_rd_en, i_meas_wr, send, cmd_valid;
  logic [7:0] i_addr, i_wr_data, o_rd_data, d;
  logic [2:0] i_meas_cell, o_conv_chan, o_adc_rate;
  logic [15:0] i_meas_data;
  logic [CMD_W-1:0] word, cmd;
  logic o_cmd_accepted, o_cmd_ignored, o_conv_start, o_busy, o_conv_done;
  logic o_discharge_suspend, o_pull_up_en, o_pull_down_en, o_continuous_discharge;
  logic o_force_redundancy_fail, o_redundancy_disable, o_discharge_timer_monitor_en;
  logic [1:0] o_conv_kind;
  logic [11:0] o_undervolt_threshold, o_overvolt_threshold;
  logic [3:0] o_discharge_timeout;
  int err_count, checks, cyc;
  host_cmd_model host_u (.i_clk_sys, .i_rst_n, .i_send(send), .i_word(word),
    .o_cmd_valid(cmd_valid), .o_cmd(cmd));
  cell_monitor_cmd_fields #(.CYC_PER_US_P(1)) dut_u (.i_clk_sys, .i_rst_n, .i_addr, .i_wr_data,
    .i_wr_en, .i_rd_en, .o_rd_data, .i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_cmd_accepted,
    .o_cmd_ignored, .i_meas_wr, .i_meas_cell, .i_meas_data, .o_conv_start, .o_conv_kind,
    .o_conv_chan, .o_adc_rate, .o_busy, .o_conv_done, .o_discharge_suspend, .o_pull_up_en,
    .o_pull_down_en, .o_undervolt_threshold, .o_overvolt_threshold, .o_discharge_timeout,
    .o_continuous_discharge, .o_force_redundancy_fail, .o_redundancy_disable,
    .o_discharge_timer_monitor_en);
  // ==========================================================================
  // bus and compare helpers
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_near(input int got, input int exp);
    checks++;
    if (got < exp - 3 || got > exp + 3) begin
      err_count++;
      $display("mismatch at %0t: took %0d cycles, expected %0d", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk_sys);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wr_data <= v;
    @(posedge i_clk_sys);
    i_wr_en <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    i_rd_en <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd_en <= 1'b0;
    #1 d = o_rd_data;
  endtask
  task send_cmd(input logic [10:0] w, input logic acc);
    @(posedge i_clk_sys);
    send <= 1'b1;
    word <= w;
    @(posedge i_clk_sys);
    send <= 1'b0;
    repeat (4) begin
      @(posedge i_clk_sys);
      #1;
      if (o_cmd_accepted === 1'b1 || o_cmd_ignored === 1'b1) break;
    end
    chk(o_cmd_accepted, acc);
    chk(o_conv_start, acc);
    chk(o_cmd_ignored, !acc);
  endtask
  task wait_done(input int us);
    int n;
    n = 0;
    while (o_conv_done !== 1'b1 && n < 40000) begin
      @(posedge i_clk_sys);
      #1 n++;
    end
    chk_near(n, us);
    chk(o_busy, 1'b0);
  endtask
  task run(input logic [10:0] w, input logic [1:0] k, input logic [2:0] c,
           input logic [2:0] r, input int us, input logic [2:0] f);
    send_cmd(w, 1'b1);
    chk(o_conv_kind, k);
    chk(o_conv_chan, c);
    chk(o_adc_rate, r);
    chk({o_discharge_suspend, o_pull_up_en, o_pull_down_en}, f);
    wait_done(us);
  endtask
  // ==========================================================================
  // scenarios
  task t_reset;
    for (int a = 0; a < 14; a++) begin
      rd(8'(a));
      chk(d, 8'h00);
    end
    // status after reset: idle, rate code 6
    rd(ADDR_STATUS);
    chk(d, 8'h60);
    rd(8'h20);
    chk(d, 8'h00);
  endtask
  task t_setup;
    wr(8'h01, 8'ha5);
    wr(8'h02, 8'h3c);
    wr(8'h03, 8'h96);
    wr(8'h05, 8'hb6);
    wr(8'h20, 8'hff);
    chk(o_undervolt_threshold, 12'hca5);
    chk(o_overvolt_threshold, 12'h963);
    chk({o_discharge_timeout, o_continuous_discharge, o_force_redundancy_fail,
      o_redundancy_disable, o_discharge_timer_monitor_en}, 8'hb6);
    rd(8'h02);
    chk(d, 8'h3c);
    rd(8'h20);
    chk(d, 8'h00);
  endtask
  task t_result;
    for (int i = 1; i <= 4; i++) begin
      @(posedge i_clk_sys);
      i_meas_wr <= 1'b1;
      i_meas_cell <= 3'(i);
      i_meas_data <= 16'(16'h1357 * i);
    end
    @(posedge i_clk_sys);
    i_meas_wr <= 1'b0;
    wr(8'h08, 8'hff);
    for (int i = 0; i < 3; i++) begin
      rd(8'(8'h08 + 2 * i));
      chk(d, 8'(16'h1357 * (i + 1)));
      rd(8'(8'h09 + 2 * i));
      chk(d, 8'((16'h1357 * (i + 1)) >> 8));
    end
  endtask
  task automatic t_kinds;
    logic [10:0] w [8] = '{11'h2e0, 11'h2fb, 11'h2ae, 11'h4e0, 11'h4e6, 11'h4e8, 11'h4ed,
      11'h4ec};
    logic [1:0] k [8] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h2, 2'h3};
    logic [2:0] c [8] = '{3'h0, 3'h3, 3'h6, 3'h0, 3'h6, 3'h0, 3'h5, 3'h4};
    logic [2:0] f [8] = '{3'h4, 3'h2, 3'h5, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
    int t [8] = '{524, 200, 200, 521, 200, 741, 200, 200};
    for (int i = 0; i < 8; i++) run(w[i], k[i], c[i], 3'h0, t[i], f[i]);
  endtask
  task automatic t_rates;
    logic [2:0] r [8] = '{3'h6, 3'h0, 3'h2, 3'h7, 3'h5, 3'h1, 3'h3, 3'h4};
    int t [8] = '{2100, 200, 404, 34000, 1200, 229, 520, 753};
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, 8'(i / 4));
      run({2'b01, 2'(i % 4), 7'h61}, 2'h0, 3'h1, r[i], t[i], 3'h4);
    end
    wr(8'h00, 8'h00);
  endtask
  task t_refuse;
    send_cmd(11'h4ef, 1'b0);
    rd(ADDR_STATUS);
    chk(d[7], 1'b1);
    wr(ADDR_STATUS, 8'h80);
    rd(ADDR_STATUS);
    chk(d[7], 1'b0);
    send_cmd(11'h2e1, 1'b1);
    send_cmd(11'h260, 1'b0);
    chk(o_conv_chan, 3'h1);
    // 200 us single cell, three cycles already spent on the refused command
    wait_done(197);
  endtask
  task test_done;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    i_clk_sys = 0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      test_done;
    end
  end
  initial begin
    {i_rst_n, i_wr_en, i_rd_en, i_meas_wr, send} = '0;
    {i_addr, i_wr_data, i_meas_cell, i_meas_data, word} = '0;
    repeat (16) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    t_reset;
    t_setup;
    t_result;
    t_kinds;
    t_rates;
    t_refuse;
    test_done;
  end
endmodule // tb_top
bind cell_monitor_cmd_fields cell_monitor_checker chk_u (.i_clk_sys, .i_rst_n, .i_addr,
  .i_wr_data, .i_wr_en, .i_cmd_valid, .i_cmd, .o_cmd_ignored, .o_conv_start, .o_conv_kind,
  .o_conv_chan, .o_busy, .o_conv_done, .o_discharge_suspend, .o_pull_up_en, .o_pull_down_en,
  .o_undervolt_threshold, .o_overvolt_threshold, .o_discharge_timeout, .o_continuous_discharge,
  .o_force_redundancy_fail, .o_redundancy_disable, .o_discharge_timer_monitor_en);
